// >>> step_ctrl_pkg.sv
// constants and types for the single-step and deceleration host controller
// Contract
// - host sets decel point: largest displacement minus decel
// - host presets point, disables decel, then starts
// - host enables decel before final node command
// - host keeps whole deceleration within one node
// - host programs equal initial and drive speeds
// - host uses drive speed above 1000PPS
// - command stop: sudden stop, wait, one step
// - host holds step input low over four clocks
// - host spaces triggers beyond one pulse period
// - external stop: sudden stop, wait, one trigger
package step_ctrl_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned STROBE_MIN_NS = 100;
  localparam int unsigned STROBE_CYCLES =
    (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TRIG_LOW_MIN_CLK = 4;
  localparam int unsigned TRIG_LOW_CYCLES = TRIG_LOW_MIN_CLK + 2;
  localparam int unsigned CNT_W = 24;

  // device parallel bus
  localparam int unsigned DEV_ADDR_W = 3;
  localparam int unsigned DEV_DATA_W = 16;
  localparam logic [2:0] ADDR_CMD = 3'h0;
  localparam logic [2:0] ADDR_INTERP_MODE = 3'h5;
  localparam int unsigned STEP_EXT_EN_BIT = 11;
  localparam int unsigned STEP_CMD_EN_BIT = 12;

  // device command codes
  localparam logic [7:0] CMD_SUDDEN_STOP = 8'h27;
  localparam logic [7:0] CMD_STEP = 8'h3a;
  localparam logic [7:0] CMD_DECEL_ON = 8'h3b;
  localparam logic [7:0] CMD_DECEL_OFF = 8'h3c;
  localparam logic [7:0] CMD_IRQ_CLEAR = 8'h3d;

  // apb register offsets
  localparam logic [7:0] OFS_OP = 8'h00;
  localparam logic [7:0] OFS_WRITE = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_PERIOD = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_RDATA = 8'h14;

  // status bits and reset values
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_IRQ = 1;
  localparam int unsigned STAT_REJECT = 2;
  localparam logic [CNT_W-1:0] PERIOD_RST = 24'h000064;
  localparam logic [15:0] CMD_WORD_RST = 16'h0000;

  typedef enum logic [3:0] {
    OP_WRITE = 4'b0000,
    OP_READ = 4'b0001,
    OP_COMMAND = 4'b0010,
    OP_CONT_START = 4'b0011,
    OP_FINAL_NODE = 4'b0100,
    OP_STEP_CMD = 4'b0101,
    OP_STEP_EXT = 4'b0110,
    OP_STOP_CMD = 4'b0111,
    OP_STOP_EXT = 4'b1000
  } op_type;

  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_WR = 2'b01,
    ACT_RD = 2'b10,
    ACT_TRIG = 2'b11
  } act_type;

endpackage : step_ctrl_pkg

// >>> dev_req_if.sv
// request path from the sequencer to the device bus engine
`timescale 1ns/100ps
interface dev_req_if;
  import step_ctrl_pkg::*;
  logic req;
  logic we;
  logic [DEV_ADDR_W-1:0] addr;
  logic [DEV_DATA_W-1:0] wdata;
  logic done;
  logic [DEV_DATA_W-1:0] rdata;
  modport requester (output req, we, addr, wdata, input done, rdata);
  modport engine (input req, we, addr, wdata, output done, rdata);
endinterface : dev_req_if

// >>> dev_bus_engine.sv
// one read or write cycle on the device parallel bus per request
`timescale 1ns/100ps
module dev_bus_engine
  import step_ctrl_pkg::*;
(
  input wire logic clk_in, // 20 MHz clock
  input wire logic rst_in, // sync reset, active high
  dev_req_if.engine rq, // request from sequencer
  output logic [DEV_ADDR_W-1:0] dev_addr_out, // device address
  output logic [DEV_DATA_W-1:0] dev_data_out, // device write data
  input wire logic [DEV_DATA_W-1:0] dev_data_in, // device read data
  output logic dev_data_oe_out, // drive data bus
  output logic dev_cs_n_out, // chip select, low active
  output logic dev_wr_n_out, // write strobe, low active
  output logic dev_rd_n_out // read strobe, low active
);
  import step_ctrl_pkg::*;

  typedef enum logic [1:0] {
    EN_IDLE = 2'b00,
    EN_SETUP = 2'b01,
    EN_STROBE = 2'b10,
    EN_HOLD = 2'b11
  } eng_state_type;

  eng_state_type state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic we_ff, nxt_we;
  logic done_ff, nxt_done;
  logic [DEV_ADDR_W-1:0] addr_ff, nxt_addr;
  logic [DEV_DATA_W-1:0] wdata_ff, nxt_wdata;
  logic [DEV_DATA_W-1:0] rdata_ff, nxt_rdata;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_we = we_ff;
    nxt_done = 1'b0;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_rdata = rdata_ff;
    unique case (state_ff)
      EN_IDLE: begin
        // done_ff blocks the request still seen in its last cycle
        if (rq.req && !done_ff) begin
          nxt_we = rq.we;
          nxt_addr = rq.addr;
          nxt_wdata = rq.wdata;
          nxt_state = EN_SETUP;
        end
      end
      EN_SETUP: begin
        nxt_cnt = 4'(STROBE_CYCLES - 1);
        nxt_state = EN_STROBE;
      end
      EN_STROBE: begin
        if (cnt_ff == 4'h0) begin
          if (!we_ff) begin
            nxt_rdata = dev_data_in;
          end
          nxt_state = EN_HOLD;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      EN_HOLD: begin
        nxt_done = 1'b1;
        nxt_state = EN_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_ff <= EN_IDLE;
      cnt_ff <= 4'h0;
      we_ff <= 1'b0;
      done_ff <= 1'b0;
      addr_ff <= '0;
      wdata_ff <= '0;
      rdata_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      we_ff <= nxt_we;
      done_ff <= nxt_done;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
    end
  end

  assign rq.done = done_ff;
  assign rq.rdata = rdata_ff;
  assign dev_addr_out = addr_ff;
  assign dev_data_out = wdata_ff;
  assign dev_data_oe_out = we_ff && (state_ff != EN_IDLE);
  assign dev_cs_n_out = (state_ff == EN_IDLE);
  assign dev_wr_n_out = !(we_ff && (state_ff == EN_STROBE));
  assign dev_rd_n_out = !(!we_ff && (state_ff == EN_STROBE));

endmodule : dev_bus_engine

// >>> step_host_ctrl.sv
// host sequencer for single-step and deceleration control of the device
`timescale 1ns/100ps
module step_host_ctrl
  import step_ctrl_pkg::*;
(
  input wire logic clk_in, // 20 MHz clock
  input wire logic rst_in, // sync reset, active high
  input wire logic [7:0] paddr_in, // apb address
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb enable
  input wire logic pwrite_in, // apb write
  input wire logic [31:0] pwdata_in, // apb write data
  output logic [31:0] prdata_out, // apb read data
  output logic pready_out, // apb ready
  output logic pslverr_out, // apb error, unmapped
  output logic [step_ctrl_pkg::DEV_ADDR_W-1:0] dev_addr_out, // dev address
  output logic [step_ctrl_pkg::DEV_DATA_W-1:0] dev_data_out, // dev wdata
  input wire logic [step_ctrl_pkg::DEV_DATA_W-1:0] dev_data_in, // dev rdata
  output logic dev_data_oe_out, // drive device data bus
  output logic dev_cs_n_out, // device select, low active
  output logic dev_wr_n_out, // device write, low active
  output logic dev_rd_n_out, // device read, low active
  output logic ext_step_trigger_n_out, // step trigger, low active
  input wire logic irq_out_n_in // device interrupt, low active
);
  import step_ctrl_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PREP = 2'b01,
    ST_ACT = 2'b10,
    ST_GAP = 2'b11
  } seq_state_type;

  dev_req_if rq ();

  // apb side state
  logic [DEV_ADDR_W-1:0] wr_addr_ff, nxt_wr_addr;
  logic [DEV_DATA_W-1:0] wr_data_ff, nxt_wr_data;
  logic [15:0] cmd_word_ff, nxt_cmd_word;
  logic [CNT_W-1:0] period_ff, nxt_period;
  logic reject_ff, nxt_reject;
  logic [DEV_DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [31:0] prdata_ff, nxt_prdata;

  // sequencer state
  seq_state_type state_ff, nxt_state;
  logic phase_ff, nxt_phase;
  // first and second device action of the current op
  act_type act1_ff, nxt_act1;
  act_type act2_ff, nxt_act2;
  logic [DEV_ADDR_W-1:0] a1_ff, nxt_a1;
  logic [DEV_ADDR_W-1:0] a2_ff, nxt_a2;
  logic [DEV_DATA_W-1:0] d1_ff, nxt_d1;
  logic [DEV_DATA_W-1:0] d2_ff, nxt_d2;
  logic gap_ff, nxt_gap;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [CNT_W-1:0] space_ff, nxt_space;
  logic trig_n_ff, nxt_trig_n;

  // interrupt line synchroniser
  logic irq_s1_ff;
  logic irq_s2_ff;
  logic irq_s3_ff;
  logic irq_lvl_ff, nxt_irq_lvl;

  logic wr_acc;
  logic rd_setup;
  logic op_wr;
  logic op_legal;
  logic mapped;
  act_type cur_act;
  logic [DEV_ADDR_W-1:0] cur_a;
  logic [DEV_DATA_W-1:0] cur_d;

  assign wr_acc = psel_in && penable_in && pwrite_in;
  assign rd_setup = psel_in && !penable_in && !pwrite_in;
  assign op_wr = wr_acc && (paddr_in == OFS_OP);
  assign op_legal = (pwdata_in[3:0] <= OP_STOP_EXT);
  // aligned words only; anything else answers with pslverr
  assign mapped = (paddr_in == OFS_OP) || (paddr_in == OFS_WRITE) ||
                  (paddr_in == OFS_CMD) || (paddr_in == OFS_PERIOD) ||
                  (paddr_in == OFS_STATUS) || (paddr_in == OFS_RDATA);
  // zero wait states: every register answers at once
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;
  assign prdata_out = prdata_ff;

  assign cur_act = phase_ff ? act2_ff : act1_ff;
  assign cur_a = phase_ff ? a2_ff : a1_ff;
  assign cur_d = phase_ff ? d2_ff : d1_ff;

  // apb registers
  always_comb begin
    nxt_wr_addr = wr_addr_ff;
    nxt_wr_data = wr_data_ff;
    nxt_cmd_word = cmd_word_ff;
    nxt_period = period_ff;
    nxt_reject = reject_ff;
    nxt_prdata = prdata_ff;
    if (wr_acc && paddr_in == OFS_WRITE) begin
      nxt_wr_addr = pwdata_in[16 +: DEV_ADDR_W];
      nxt_wr_data = pwdata_in[DEV_DATA_W-1:0];
    end
    if (wr_acc && paddr_in == OFS_CMD) begin
      nxt_cmd_word = pwdata_in[15:0];
    end
    if (wr_acc && paddr_in == OFS_PERIOD) begin
      nxt_period = pwdata_in[CNT_W-1:0];
    end
    if (wr_acc && paddr_in == OFS_STATUS && pwdata_in[STAT_REJECT]) begin
      nxt_reject = 1'b0;
    end
    // set wins over the clear
    // an op while busy is dropped, never queued
    if (op_wr && (state_ff != ST_IDLE || !op_legal)) begin
      nxt_reject = 1'b1;
    end
    // read data is caught in the setup cycle
    if (rd_setup) begin
      nxt_prdata = 32'h0000_0000;
      unique case (paddr_in)
        OFS_WRITE: nxt_prdata = {13'h0000, wr_addr_ff, wr_data_ff};
        OFS_CMD: nxt_prdata = {16'h0000, cmd_word_ff};
        OFS_PERIOD: nxt_prdata = {8'h00, period_ff};
        OFS_STATUS: nxt_prdata = {29'h0000_0000, reject_ff, irq_lvl_ff,
                                  state_ff != ST_IDLE};
        OFS_RDATA: nxt_prdata = {16'h0000, rdata_ff};
        default: nxt_prdata = 32'h0000_0000;
      endcase
    end
    if (state_ff == ST_ACT && rq.done && cur_act == ACT_RD) begin
      nxt_rdata = rq.rdata;
    end else begin
      nxt_rdata = rdata_ff;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_addr_ff <= '0;
      wr_data_ff <= '0;
      cmd_word_ff <= CMD_WORD_RST;
      period_ff <= PERIOD_RST;
      reject_ff <= 1'b0;
      rdata_ff <= '0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      wr_addr_ff <= nxt_wr_addr;
      wr_data_ff <= nxt_wr_data;
      cmd_word_ff <= nxt_cmd_word;
      period_ff <= nxt_period;
      reject_ff <= nxt_reject;
      rdata_ff <= nxt_rdata;
      prdata_ff <= nxt_prdata;
    end
  end

  // sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_phase = phase_ff;
    nxt_act1 = act1_ff;
    nxt_act2 = act2_ff;
    nxt_a1 = a1_ff;
    nxt_a2 = a2_ff;
    nxt_d1 = d1_ff;
    nxt_d2 = d2_ff;
    nxt_gap = gap_ff;
    nxt_cnt = cnt_ff;
    nxt_trig_n = trig_n_ff;
    nxt_space = (space_ff != '0) ? space_ff - 24'h000001 : space_ff;
    unique case (state_ff)
      ST_IDLE: begin
        // defaults give a plain write of the command word
        if (op_wr && op_legal) begin
          nxt_phase = 1'b0;
          nxt_gap = 1'b0;
          nxt_act2 = ACT_NONE;
          nxt_a1 = ADDR_CMD;
          nxt_a2 = ADDR_CMD;
          nxt_d1 = cmd_word_ff;
          nxt_d2 = cmd_word_ff;
          nxt_act1 = ACT_WR;
          nxt_state = ST_PREP;
          unique case (op_type'(pwdata_in[3:0]))
            OP_WRITE: begin
              // software sets decel point and speeds this way
              nxt_a1 = wr_addr_ff;
              nxt_d1 = wr_data_ff;
            end
            OP_READ: begin
              nxt_act1 = ACT_RD;
              nxt_a1 = wr_addr_ff;
            end
            OP_COMMAND: begin
            end
            OP_CONT_START: begin
              nxt_d1 = {cmd_word_ff[15:8], CMD_DECEL_OFF};
              nxt_act2 = ACT_WR;
            end
            OP_FINAL_NODE: begin
              nxt_d1 = {cmd_word_ff[15:8], CMD_DECEL_ON};
              nxt_act2 = ACT_WR;
            end
            OP_STEP_CMD: begin
              nxt_d1 = {cmd_word_ff[15:8], CMD_STEP};
            end
            OP_STEP_EXT: begin
              nxt_act1 = ACT_TRIG;
            end
            OP_STOP_CMD: begin
              nxt_d1 = {cmd_word_ff[15:8], CMD_SUDDEN_STOP};
              nxt_d2 = {cmd_word_ff[15:8], CMD_STEP};
              nxt_act2 = ACT_WR;
              nxt_gap = 1'b1;
            end
            OP_STOP_EXT: begin
              nxt_d1 = {cmd_word_ff[15:8], CMD_SUDDEN_STOP};
              nxt_act2 = ACT_TRIG;
              nxt_gap = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      ST_PREP: begin
        if (cur_act == ACT_NONE) begin
          nxt_state = ST_IDLE;
        end else if (cur_act == ACT_TRIG) begin
          // spacing from the last release
          if (space_ff == '0) begin
            nxt_trig_n = 1'b0;
            nxt_cnt = CNT_W'(TRIG_LOW_CYCLES - 1);
            nxt_state = ST_ACT;
          end
        end else begin
          nxt_state = ST_ACT;
        end
      end
      ST_ACT: begin
        if (cur_act == ACT_TRIG) begin
          if (cnt_ff == '0) begin
            nxt_trig_n = 1'b1;
            nxt_space = period_ff;
          end else begin
            nxt_cnt = cnt_ff - 24'h000001;
          end
        end
        if ((cur_act == ACT_TRIG && cnt_ff == '0) ||
            (cur_act != ACT_TRIG && rq.done)) begin
          if (!phase_ff && act2_ff != ACT_NONE) begin
            nxt_phase = 1'b1;
            if (gap_ff) begin
              // more than one pulse period
              nxt_cnt = period_ff;
              nxt_state = ST_GAP;
            end else begin
              nxt_state = ST_PREP;
            end
          end else begin
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_GAP: begin
        // period+1 clocks between the stop and the last step
        if (cnt_ff == '0) begin
          nxt_state = ST_PREP;
        end else begin
          nxt_cnt = cnt_ff - 24'h000001;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_ff <= ST_IDLE;
      phase_ff <= 1'b0;
      act1_ff <= ACT_NONE;
      act2_ff <= ACT_NONE;
      a1_ff <= '0;
      a2_ff <= '0;
      d1_ff <= '0;
      d2_ff <= '0;
      gap_ff <= 1'b0;
      cnt_ff <= '0;
      space_ff <= '0;
      trig_n_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      phase_ff <= nxt_phase;
      act1_ff <= nxt_act1;
      act2_ff <= nxt_act2;
      a1_ff <= nxt_a1;
      a2_ff <= nxt_a2;
      d1_ff <= nxt_d1;
      d2_ff <= nxt_d2;
      gap_ff <= nxt_gap;
      cnt_ff <= nxt_cnt;
      space_ff <= nxt_space;
      trig_n_ff <= nxt_trig_n;
    end
  end

  // interrupt level, taken once stages two and three agree
  always_comb begin
    nxt_irq_lvl = irq_lvl_ff;
    if (irq_s2_ff == irq_s3_ff) begin
      nxt_irq_lvl = !irq_s3_ff;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_s1_ff <= 1'b1;
      irq_s2_ff <= 1'b1;
      irq_s3_ff <= 1'b1;
      irq_lvl_ff <= 1'b0;
    end else begin
      irq_s1_ff <= irq_out_n_in;
      irq_s2_ff <= irq_s1_ff;
      irq_s3_ff <= irq_s2_ff;
      irq_lvl_ff <= nxt_irq_lvl;
    end
  end

  assign rq.req = (state_ff == ST_ACT) && (cur_act != ACT_TRIG);
  assign rq.we = (cur_act == ACT_WR);
  assign rq.addr = cur_a;
  assign rq.wdata = cur_d;
  assign ext_step_trigger_n_out = trig_n_ff;

  // one device bus cycle per request; done ends it
  dev_bus_engine dev_bus_engine_i (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .rq(rq),
    .dev_addr_out(dev_addr_out),
    .dev_data_out(dev_data_out),
    .dev_data_in(dev_data_in),
    .dev_data_oe_out(dev_data_oe_out),
    .dev_cs_n_out(dev_cs_n_out),
    .dev_wr_n_out(dev_wr_n_out),
    .dev_rd_n_out(dev_rd_n_out)
  );

endmodule : step_host_ctrl

// >>> step_dev_model.sv
// device model: command decoder, step counter, interrupt line
`timescale 1ns/100ps
module step_dev_model
  import step_ctrl_pkg::*;
(
  input wire logic clk_in, // clock
  input wire logic rst_in, // reset
  input wire logic [2:0] addr_in, // address
  input wire logic [15:0] data_in, // data bus
  input wire logic cs_n_in, // select
  input wire logic wr_n_in, // write
  input wire logic rd_n_in, // read
  input wire logic trig_n_in, // step trigger
  output logic [15:0] data_out, // read data
  output wire irq_n_out // open drain irq
);
  logic [15:0] mode_ff, cnt_ff, last_ff, rval;
  logic decel_ff, armed_ff, stop_ff, irq_ff, wr_d_ff, trig_d_ff;
  logic wr_now, step;
  logic [7:0] code;
  assign code = data_in[7:0];
  assign wr_now = wr_n_in && !wr_d_ff && !cs_n_in;
  assign step = (wr_now && addr_in == ADDR_CMD && code == CMD_STEP
    && mode_ff[STEP_CMD_EN_BIT])
    || (!trig_n_in && trig_d_ff && mode_ff[STEP_EXT_EN_BIT]);
  assign irq_n_out = irq_ff ? 1'b0 : 1'bz;
  always_comb begin
    case (addr_in)
      3'h0: rval = {12'h000, irq_ff, stop_ff, armed_ff, decel_ff};
      3'h1: rval = cnt_ff;
      3'h5: rval = mode_ff;
      default: rval = 16'h0000;
    endcase
  end
  // released bus toggles so stale data never matches
  assign data_out = (!cs_n_in && !rd_n_in) ? rval : ~last_ff;
  always_ff @(posedge clk_in) begin
    wr_d_ff <= wr_n_in;
    trig_d_ff <= trig_n_in;
    last_ff <= data_out;
    if (rst_in) begin
      mode_ff <= 16'h0000;
      decel_ff <= 1'b0;
      {cnt_ff, armed_ff, stop_ff, irq_ff} <= '0;
    end else begin
      if (wr_now && addr_in == ADDR_INTERP_MODE) mode_ff <= data_in;
      if (wr_now && addr_in == ADDR_CMD) begin
        case (code)
          CMD_DECEL_ON: decel_ff <= 1'b1;
          CMD_DECEL_OFF: decel_ff <= 1'b0;
          CMD_SUDDEN_STOP: stop_ff <= armed_ff;
          CMD_IRQ_CLEAR: irq_ff <= 1'b0;
          default: if (code[7:4] == 4'h3 && code < CMD_STEP) begin
            armed_ff <= 1'b1;
            cnt_ff <= 16'h0000;
            irq_ff <= 1'b0;
          end
        endcase
      end
      if (step && armed_ff) begin
        if (stop_ff) begin
          {armed_ff, stop_ff} <= 2'b00;
        end else begin
          cnt_ff <= cnt_ff + 16'h0001;
          irq_ff <= irq_ff | mode_ff[14] | mode_ff[15];
        end
      end
    end
  end
endmodule : step_dev_model

// >>> step_host_ctrl_props.sv
// port assertions for the step host controller
`timescale 1ns/100ps
module step_host_ctrl_props
  import step_ctrl_pkg::*;
(
  input wire logic clk_in, // clock
  input wire logic rst_in, // reset
  input wire logic [7:0] paddr_in, // apb address
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb enable
  input wire logic pready_out, // apb ready
  input wire logic pslverr_out, // apb error
  input wire logic [2:0] dev_addr_out, // dev address
  input wire logic dev_data_oe_out, // dev drive
  input wire logic dev_cs_n_out, // dev select
  input wire logic dev_wr_n_out, // dev write
  input wire logic dev_rd_n_out, // dev read
  input wire logic ext_step_trigger_n_out // trigger
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  apb_ready_a: assert property (psel_in |-> pready_out)
    else $error("pready low in a transfer");
  unmapped_err_a: assert property (psel_in && penable_in
    && paddr_in > OFS_RDATA |-> pslverr_out)
    else $error("no error on unmapped address");
  mapped_ok_a: assert property (psel_in && penable_in
    && paddr_in <= OFS_RDATA && paddr_in[1:0] == 2'b00 |-> !pslverr_out)
    else $error("error on mapped address");
  wr_setup_a: assert property ($fell(dev_wr_n_out)
    |-> !dev_cs_n_out && $past(!dev_cs_n_out))
    else $error("write strobe without setup");
  wr_cycle_a: assert property ($fell(dev_wr_n_out) |=> !dev_wr_n_out
    ##1 dev_wr_n_out && !dev_cs_n_out ##1 dev_cs_n_out)
    else $error("write cycle shape wrong");
  rd_cycle_a: assert property ($fell(dev_rd_n_out) |=> !dev_rd_n_out
    ##1 dev_rd_n_out && !dev_cs_n_out ##1 dev_cs_n_out)
    else $error("read cycle shape wrong");
  wr_drive_a: assert property (!dev_wr_n_out
    |-> dev_data_oe_out && !dev_cs_n_out && dev_rd_n_out)
    else $error("write without bus drive");
  rd_float_a: assert property (!dev_rd_n_out
    |-> !dev_data_oe_out && !dev_cs_n_out)
    else $error("bus driven in a read");
  addr_hold_a: assert property (!dev_cs_n_out && $past(!dev_cs_n_out)
    |-> $stable(dev_addr_out) && $stable(dev_data_oe_out))
    else $error("address moved in a cycle");
  trig_low_a: assert property ($fell(ext_step_trigger_n_out) |->
    !ext_step_trigger_n_out[*6] ##1 ext_step_trigger_n_out)
    else $error("trigger low time wrong");
  trig_c: cover property ($fell(ext_step_trigger_n_out));
  wr_c: cover property ($fell(dev_wr_n_out));
  rd_c: cover property ($fell(dev_rd_n_out));
  err_c: cover property (pslverr_out && penable_in);
endmodule : step_host_ctrl_props

// >>> testbench.sv
// self-checking bench for the step host controller
`timescale 1ns/100ps
module testbench;
  import step_ctrl_pkg::*;
  logic clk_in, rst_in, psel_in, penable_in, pwrite_in;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd, rnd, per;
  logic pready_out, pslverr_out, oe, cs_n, wr_n, rd_n, trig_n;
  logic [2:0] dev_addr;
  logic [15:0] dev_wd, mdl_data, bus, mode;
  logic [33:0] expq[$];
  logic [33:0] e;
  wire irq_w;
  int n_mismatch = 0;
  int n_checks = 0;
  pullup (irq_w);
  assign bus = oe ? dev_wd : mdl_data;
  step_host_ctrl step_host_ctrl_i (.clk_in(clk_in), .rst_in(rst_in),
    .paddr_in(paddr_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .dev_addr_out(dev_addr), .dev_data_out(dev_wd), .dev_data_in(bus),
    .dev_data_oe_out(oe), .dev_cs_n_out(cs_n), .dev_wr_n_out(wr_n),
    .dev_rd_n_out(rd_n), .ext_step_trigger_n_out(trig_n),
    .irq_out_n_in(irq_w));
  step_dev_model step_dev_model_i (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(dev_addr), .data_in(bus), .cs_n_in(cs_n), .wr_n_in(wr_n),
    .rd_n_in(rd_n), .trig_n_in(trig_n), .data_out(mdl_data),
    .irq_n_out(irq_w));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic check(input string nm, input logic [32:0] seen,
                       input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [33:0] x);
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    if (!w) expq.push_back(x);
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [7:0] a, input logic er,
                        input logic [31:0] d);
    apb(1'b0, a, 32'h0, {1'b1, er, d});
  endtask : rd_chk
  task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
    int k;
    k = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0, '0);
      k++;
    end while ((rd & m) !== v && k < 200);
    if ((rd & m) !== v) check("status wait", {1'b0, rd & m}, {1'b0, v});
  endtask : wait_stat
  task automatic op(input op_type c);
    apb(1'b1, OFS_OP, {28'h0, c}, '0);
    wait_stat(32'h1, 32'h0);
  endtask : op
  task automatic devw(input logic [2:0] a, input logic [15:0] d);
    apb(1'b1, OFS_WRITE, {13'h0, a, d}, '0);
    op(OP_WRITE);
  endtask : devw
  task automatic devr(input logic [2:0] a, input logic [15:0] d);
    apb(1'b1, OFS_WRITE, {13'h0, a, 16'h0}, '0);
    op(OP_READ);
    rd_chk(OFS_RDATA, 1'b0, {16'h0, d});
  endtask : devr
  task automatic cmdw(input logic [15:0] c);
    apb(1'b1, OFS_CMD, {16'h0, c}, '0);
    op(OP_COMMAND);
  endtask : cmdw
  always @(posedge clk_in) begin
    if (psel_in && penable_in && pready_out && !pwrite_in) begin
      e = expq.pop_front();
      if (e[33]) check("apb read", {pslverr_out, prdata_out}, e[32:0]);
    end
  end
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  initial begin
    repeat (40000) @(posedge clk_in);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {psel_in, penable_in, pwrite_in} <= 3'b000;
    paddr_in <= 8'h00;
    pwdata_in <= 32'h0;
    rst_in <= 1'b1;
    rnd = 32'h00000050;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    rd_chk(OFS_STATUS, 1'b0, 32'h0);
    rd_chk(OFS_PERIOD, 1'b0, {8'h00, PERIOD_RST});
    rd_chk(OFS_CMD, 1'b0, {16'h0, CMD_WORD_RST});
    rnd = xs(rnd);
    per = {27'h0, rnd[4:0]} + 32'h8;
    apb(1'b1, OFS_PERIOD, per, '0);
    rd_chk(OFS_PERIOD, 1'b0, per);
    apb(1'b1, 8'h40, 32'h1234, '0);
    rd_chk(8'h40, 1'b1, 32'h0);
    apb(1'b1, OFS_OP, 32'h9, '0);
    rd_chk(OFS_STATUS, 1'b0, 32'h4);
    apb(1'b1, OFS_STATUS, 32'h4, '0);
    rd_chk(OFS_STATUS, 1'b0, 32'h0);
    devr(3'h0, 16'h0000);
    rnd = xs(rnd);
    mode = {4'b0001, 1'b0, rnd[10:0]};
    devw(ADDR_INTERP_MODE, mode);
    devr(ADDR_INTERP_MODE, mode);
    op(OP_STEP_CMD);
    devr(3'h1, 16'h0000);
    cmdw(16'h0030);
    devr(3'h1, 16'h0000);
    op(OP_STEP_CMD);
    op(OP_STEP_CMD);
    devr(3'h1, 16'h0002);
    op(OP_STOP_CMD);
    op(OP_STEP_CMD);
    devr(3'h1, 16'h0002);
    devw(ADDR_INTERP_MODE, 16'h0800);
    cmdw(16'h0030);
    op(OP_STEP_EXT);
    op(OP_STEP_EXT);
    devr(3'h1, 16'h0002);
    op(OP_STOP_EXT);
    op(OP_STEP_EXT);
    devr(3'h1, 16'h0002);
    op(OP_CONT_START);
    devr(3'h0, 16'h0002);
    op(OP_FINAL_NODE);
    devr(3'h0, 16'h0003);
    for (int i = 0; i < 2; i++) begin
      devw(ADDR_INTERP_MODE, i == 0 ? 16'h5000 : 16'h9000);
      cmdw(16'h0030);
      op(OP_STEP_CMD);
      wait_stat(32'h2, 32'h2);
      rd_chk(OFS_STATUS, 1'b0, 32'h2);
      cmdw(16'h003d);
      wait_stat(32'h2, 32'h0);
      rd_chk(OFS_STATUS, 1'b0, 32'h0);
    end
    print_verdict();
  end
endmodule : testbench
bind step_host_ctrl step_host_ctrl_props step_host_ctrl_props_i (
  .clk_in(clk_in), .rst_in(rst_in), .paddr_in(paddr_in),
  .psel_in(psel_in), .penable_in(penable_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .dev_addr_out(dev_addr_out),
  .dev_data_oe_out(dev_data_oe_out), .dev_cs_n_out(dev_cs_n_out),
  .dev_wr_n_out(dev_wr_n_out), .dev_rd_n_out(dev_rd_n_out),
  .ext_step_trigger_n_out(ext_step_trigger_n_out));
